// File: design/charge_cfg_pkg.sv
// Constants for the charge parameter register bank: register indices,
// reset values, field positions, decode weights and watchdog timing.
// Assumes a single 50 MHz clock domain.
package charge_cfg_pkg;

	// Clock and watchdog time base
	localparam int unsigned CLOCK_HZ        = 50_000_000;
	localparam int unsigned WDOG_TICK_MS    = 1;
	localparam int unsigned WDOG_TICK_CYCLES =
		CLOCK_HZ / 1000 * WDOG_TICK_MS;
	localparam int unsigned MS_PER_S        = 1000;
	localparam int unsigned WDOG_SHORT_S    = 40;
	localparam int unsigned WDOG_MID_S      = 80;
	localparam int unsigned WDOG_LONG_S     = 160;
	localparam logic [17:0] WDOG_SHORT_TICKS =
		18'(WDOG_SHORT_S * MS_PER_S / WDOG_TICK_MS);
	localparam logic [17:0] WDOG_MID_TICKS   =
		18'(WDOG_MID_S * MS_PER_S / WDOG_TICK_MS);
	localparam logic [17:0] WDOG_LONG_TICKS  =
		18'(WDOG_LONG_S * MS_PER_S / WDOG_TICK_MS);

	// Register indices on the register port
	localparam logic [7:0] PRECHG_TERM_IDX  = 8'h03;
	localparam logic [7:0] CHG_VOLT_IDX     = 8'h04;
	localparam logic [7:0] TERM_TIMER_IDX   = 8'h05;

	// Reset values
	localparam logic [7:0] PRECHG_TERM_RST  = 8'h11;
	localparam logic [7:0] CHG_VOLT_RST     = 8'hB2;
	localparam logic [7:0] TERM_TIMER_RST   = 8'h9C;

	// Writable bits; reserved bits are held at zero
	localparam logic [7:0] PRECHG_TERM_MASK = 8'hF7;
	localparam logic [7:0] CHG_VOLT_MASK    = 8'hFF;
	localparam logic [7:0] TERM_TIMER_MASK  = 8'hBE;

	// Field positions
	localparam int unsigned PRECHG_LSB      = 4;
	localparam int unsigned TERM_LSB        = 0;
	localparam int unsigned CHARGE_VOLTAGE_CODE_LSB        = 2;
	localparam int unsigned LOW_BATT_BIT    = 1;
	localparam int unsigned RECHG_BIT       = 0;
	localparam int unsigned TERM_EN_BIT     = 7;
	localparam int unsigned WDOG_LSB        = 4;
	localparam int unsigned SAFETY_EN_BIT   = 3;
	localparam int unsigned FAST_LIMIT_LSB  = 1;

	// Decode weights
	localparam logic [11:0] CURRENT_STEP_MA = 12'h080;
	localparam logic [11:0] CURRENT_BASE_MA = 12'h080;
	localparam logic [12:0] CHARGE_VOLTAGE_CODE_BASE_MV    = 13'h0DB0;
	localparam logic [12:0] CHARGE_VOLTAGE_CODE_STEP_MV    = 13'h0010;
	localparam logic [12:0] CHARGE_VOLTAGE_CODE_MAX_MV     = 13'h1130;
	localparam logic [11:0] LOW_BATT_LO_MV  = 12'hAF0;
	localparam logic [11:0] LOW_BATT_HI_MV  = 12'hBB8;
	localparam logic [12:0] RECHG_LO_MV     = 13'h0064;
	localparam logic [12:0] RECHG_HI_MV     = 13'h012C;
	localparam logic [11:0] FAST_DIVISOR    = 12'h005;
	localparam logic [4:0]  FAST_LIMIT_H0   = 5'h05;
	localparam logic [4:0]  FAST_LIMIT_H1   = 5'h08;
	localparam logic [4:0]  FAST_LIMIT_H2   = 5'h0C;
	localparam logic [4:0]  FAST_LIMIT_H3   = 5'h14;

	typedef enum logic [1:0] {
		WDOG_OFF   = 2'b00,
		WDOG_SHORT = 2'b01,
		WDOG_MID   = 2'b10,
		WDOG_LONG  = 2'b11
	} watchdog_sel_t;

endpackage : charge_cfg_pkg

// File: design/cfg_reg_if.sv
// Carrier between the bank and one configuration register.
// Assumes the owner drives load, wdata and defaults on the same clock.
`timescale 1ns/100ps
interface cfg_reg_if;
	logic       load;
	logic       defaults;
	logic [7:0] wdata;
	logic [7:0] value;

	modport ctrl  (output load, output defaults, output wdata, input value);
	modport store (input load, input defaults, input wdata, output value);
endinterface : cfg_reg_if

// File: design/cfg_reg.sv
// One 8-bit configuration register with reset value and writable mask.
// Assumes load and defaults are one-cycle strobes from the same clock.
`timescale 1ns/100ps
module cfg_reg #(
	parameter logic [7:0] RESET_VALUE = 8'h00,
	parameter logic [7:0] WRITE_MASK  = 8'hFF
) (
	input  wire logic clock,
	input  wire logic rst,
	cfg_reg_if.store  port
);
	logic [7:0] value;

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			value <= RESET_VALUE;
		else if (port.defaults)
			value <= RESET_VALUE;
		else if (port.load)
			value <= port.wdata & WRITE_MASK;
	end

	assign port.value = value;
endmodule : cfg_reg

// File: design/charge_parameter_registers.sv
// Charge parameter register bank: three configuration registers, their
// decoded charge settings and the host watchdog counter.
// Assumes the serial engine presents register accesses on the same clock
// as single-cycle strobes, and the charge current block shares the clock.
//
// Summary of operation
// - Pre-charge code times 128 mA; codes 0 and 1 give 128 mA, codes 4 and up add 128 mA
// - Pre-charge code resets to 0001
// - Termination current 128 mA offset plus weights
// - Termination code resets to 001
// - Charge voltage 3.504 V plus 16 mV steps
// - Low-battery threshold 2.8 V or 3.0 V
// - Recharge 100 mV or 300 mV below regulation
// - Termination enable bit, reset set
// - Watchdog off, 40 s, 80 s, 160 s
// - Safety timer enable bit, reset set
// - Fast-charge limit 5, 8, 12, 20 hours
// - Registers reset to 0x11, 0xB2, 0x9C
// - Reduced mode: half pre-charge, fifth fast-charge
`timescale 1ns/100ps
module charge_parameter_registers
	import charge_cfg_pkg::*;
#(
	parameter int unsigned WDOG_TICK_CYCLES_P = charge_cfg_pkg::WDOG_TICK_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_write,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_read,
	output logic      [7:0]  reg_rdata,
	output logic             reg_hit,
	input  wire logic        defaults_load,
	input  wire logic        watchdog_kick,
	input  wire logic        reduced_current_force,
	input  wire logic [11:0] fast_charge_current_ma,
	output logic      [11:0] precharge_current_ma,
	output logic      [11:0] applied_precharge_ma,
	output logic      [11:0] applied_fast_charge_ma,
	output logic      [11:0] termination_current_ma,
	output logic      [12:0] charge_voltage_mv,
	output logic      [11:0] low_battery_threshold_mv,
	output logic      [12:0] recharge_threshold_mv,
	output logic             termination_enable,
	output logic             safety_timer_enable,
	output logic      [4:0]  fast_charge_limit_hours,
	output logic             watchdog_expired
);
	import charge_cfg_pkg::*;

	// Register port decode
	wire logic sel_prechg;
	wire logic sel_volt;
	wire logic sel_timer;

	assign sel_prechg = reg_addr == PRECHG_TERM_IDX;
	assign sel_volt   = reg_addr == CHG_VOLT_IDX;
	assign sel_timer  = reg_addr == TERM_TIMER_IDX;
	assign reg_hit    = sel_prechg | sel_volt | sel_timer;

	cfg_reg_if prechg_bus ();
	cfg_reg_if volt_bus ();
	cfg_reg_if timer_bus ();

	assign prechg_bus.load     = reg_write & sel_prechg;
	assign prechg_bus.wdata    = reg_wdata;
	assign prechg_bus.defaults = defaults_load;
	assign volt_bus.load       = reg_write & sel_volt;
	assign volt_bus.wdata      = reg_wdata;
	assign volt_bus.defaults   = defaults_load;
	assign timer_bus.load      = reg_write & sel_timer;
	assign timer_bus.wdata     = reg_wdata;
	assign timer_bus.defaults  = defaults_load;

	cfg_reg #(
		.RESET_VALUE (PRECHG_TERM_RST),
		.WRITE_MASK  (PRECHG_TERM_MASK)
	) prechg_reg (
		.clock (clock),
		.rst   (rst),
		.port  (prechg_bus.store)
	);

	cfg_reg #(
		.RESET_VALUE (CHG_VOLT_RST),
		.WRITE_MASK  (CHG_VOLT_MASK)
	) volt_reg (
		.clock (clock),
		.rst   (rst),
		.port  (volt_bus.store)
	);

	cfg_reg #(
		.RESET_VALUE (TERM_TIMER_RST),
		.WRITE_MASK  (TERM_TIMER_MASK)
	) timer_reg (
		.clock (clock),
		.rst   (rst),
		.port  (timer_bus.store)
	);

	wire logic [7:0] prechg_value;
	wire logic [7:0] volt_value;
	wire logic [7:0] timer_value;

	assign prechg_value = prechg_bus.value;
	assign volt_value   = volt_bus.value;
	assign timer_value  = timer_bus.value;

	// Read data; unmapped indices read zero
	wire logic [7:0] read_mux;

	assign read_mux = sel_prechg ? prechg_value :
		sel_volt ? volt_value :
		sel_timer ? timer_value : 8'h00;

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_read)
			reg_rdata <= read_mux;
	end

	// Field extraction
	wire logic [3:0]    precharge_current_code;
	wire logic [2:0]    termination_current_code;
	wire logic [5:0]    charge_voltage_code;
	wire logic          low_battery_threshold_sel;
	wire logic          recharge_offset_sel;
	wire logic [1:0]    fast_charge_limit_sel;
	wire watchdog_sel_t watchdog_sel;

	assign precharge_current_code    = prechg_value[PRECHG_LSB +: 4];
	assign termination_current_code  = prechg_value[TERM_LSB +: 3];
	assign charge_voltage_code       = volt_value[CHARGE_VOLTAGE_CODE_LSB +: 6];
	assign low_battery_threshold_sel = volt_value[LOW_BATT_BIT];
	assign recharge_offset_sel       = volt_value[RECHG_BIT];
	assign fast_charge_limit_sel     = timer_value[FAST_LIMIT_LSB +: 2];
	assign watchdog_sel = watchdog_sel_t'(timer_value[WDOG_LSB +: 2]);

	// Current decode
	wire logic [11:0] prechg_code_ma;
	wire logic [11:0] prechg_step_ma;
	wire logic [11:0] next_precharge_ma;
	wire logic [11:0] next_term_ma;
	wire logic [11:0] next_applied_prechg;
	wire logic [11:0] next_applied_fast;

	assign prechg_code_ma = 12'(precharge_current_code) * CURRENT_STEP_MA;
	assign prechg_step_ma = prechg_code_ma + CURRENT_STEP_MA;
	// Codes 0 and 1 both give the base; codes 4 and above gain one extra step
	assign next_precharge_ma =
		(precharge_current_code <= 4'h1) ? CURRENT_BASE_MA :
		(precharge_current_code <= 4'h3) ? prechg_code_ma :
		prechg_step_ma;
	assign next_term_ma = CURRENT_BASE_MA +
		12'(termination_current_code) * CURRENT_STEP_MA;
	assign next_applied_prechg = reduced_current_force ?
		{1'b0, next_precharge_ma[11:1]} : next_precharge_ma;
	assign next_applied_fast = reduced_current_force ?
		fast_charge_current_ma / FAST_DIVISOR :
		fast_charge_current_ma;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			precharge_current_ma   <= 12'h000;
			applied_precharge_ma   <= 12'h000;
			applied_fast_charge_ma <= 12'h000;
			termination_current_ma <= 12'h000;
		end else begin
			precharge_current_ma   <= next_precharge_ma;
			applied_precharge_ma   <= next_applied_prechg;
			applied_fast_charge_ma <= next_applied_fast;
			termination_current_ma <= next_term_ma;
		end
	end

	// Voltage decode; codes past the top of range clamp to it
	wire logic [12:0] charge_voltage_code_raw_mv;
	wire logic [12:0] next_charge_voltage_code_mv;
	wire logic [11:0] next_low_batt_mv;
	wire logic [12:0] next_rechg_mv;

	assign charge_voltage_code_raw_mv = CHARGE_VOLTAGE_CODE_BASE_MV +
		13'(charge_voltage_code) * CHARGE_VOLTAGE_CODE_STEP_MV;
	assign next_charge_voltage_code_mv = (charge_voltage_code_raw_mv > CHARGE_VOLTAGE_CODE_MAX_MV) ?
		CHARGE_VOLTAGE_CODE_MAX_MV : charge_voltage_code_raw_mv;
	assign next_low_batt_mv = low_battery_threshold_sel ?
		LOW_BATT_HI_MV : LOW_BATT_LO_MV;
	// Recharge level follows the clamped regulation voltage
	assign next_rechg_mv = next_charge_voltage_code_mv -
		(recharge_offset_sel ? RECHG_HI_MV : RECHG_LO_MV);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			charge_voltage_mv        <= 13'h0000;
			low_battery_threshold_mv <= 12'h000;
			recharge_threshold_mv    <= 13'h0000;
		end else begin
			charge_voltage_mv        <= next_charge_voltage_code_mv;
			low_battery_threshold_mv <= next_low_batt_mv;
			recharge_threshold_mv    <= next_rechg_mv;
		end
	end

	// Control flags and fast-charge limit
	logic [4:0] next_limit_hours;

	always_comb begin
		unique case (fast_charge_limit_sel)
			2'b00: next_limit_hours = FAST_LIMIT_H0;
			2'b01: next_limit_hours = FAST_LIMIT_H1;
			2'b10: next_limit_hours = FAST_LIMIT_H2;
			2'b11: next_limit_hours = FAST_LIMIT_H3;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			termination_enable      <= 1'b0;
			safety_timer_enable     <= 1'b0;
			fast_charge_limit_hours <= 5'h00;
		end else begin
			termination_enable      <= timer_value[TERM_EN_BIT];
			safety_timer_enable     <= timer_value[SAFETY_EN_BIT];
			fast_charge_limit_hours <= next_limit_hours;
		end
	end

	// Host watchdog: a tick divider feeds a tick counter
	logic [17:0] wdog_limit;
	logic        wdog_off;

	always_comb begin
		wdog_off = 1'b0;
		unique case (watchdog_sel)
			WDOG_OFF: begin
				wdog_limit = WDOG_SHORT_TICKS;
				wdog_off   = 1'b1;
			end
			WDOG_SHORT: wdog_limit = WDOG_SHORT_TICKS;
			WDOG_MID:   wdog_limit = WDOG_MID_TICKS;
			WDOG_LONG:  wdog_limit = WDOG_LONG_TICKS;
		endcase
	end

	watchdog_sel_t wdog_sel_prev;
	logic [15:0]   tick_count;
	logic [17:0]   wdog_count;

	wire logic wdog_restart;
	wire logic tick_hit;
	wire logic expire_hit;

	// Kicks arrive no closer than the host's minimum spacing
	assign wdog_restart = watchdog_kick |
		(watchdog_sel != wdog_sel_prev);
	assign tick_hit = tick_count == 16'(WDOG_TICK_CYCLES_P - 1);
	assign expire_hit = tick_hit & ~wdog_off & ~watchdog_expired &
		(wdog_count == wdog_limit - 18'h00001);

	// Seeded with the field's reset code so reset brings no false restart
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			wdog_sel_prev <= WDOG_SHORT;
		else
			wdog_sel_prev <= watchdog_sel;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			tick_count <= 16'h0000;
		else if (wdog_restart | wdog_off | tick_hit)
			tick_count <= 16'h0000;
		else
			tick_count <= tick_count + 16'h0001;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			wdog_count <= 18'h00000;
		else if (wdog_restart | wdog_off)
			wdog_count <= 18'h00000;
		else if (tick_hit & ~watchdog_expired)
			wdog_count <= wdog_count + 18'h00001;
	end

	// Expiry stays until restarted; an expiry in a restart cycle wins
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			watchdog_expired <= 1'b0;
		else if (expire_hit)
			watchdog_expired <= 1'b1;
		else if (wdog_restart | wdog_off)
			watchdog_expired <= 1'b0;
	end
endmodule : charge_parameter_registers

// File: dv/charge_parameter_registers_monitor.sv
// Checker for the charge parameter register bank.
// Assumes one clock and reset; sees only the bank's top ports.
`timescale 1ns/100ps
module charge_parameter_registers_monitor (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [7:0]  reg_rdata,
	input wire logic        reg_hit,
	input wire logic [7:0]  reg_wdata,
	input wire logic        defaults_load,
	input wire logic        watchdog_kick,
	input wire logic        reduced_current_force,
	input wire logic [11:0] fast_charge_current_ma,
	input wire logic [11:0] precharge_current_ma,
	input wire logic [11:0] applied_precharge_ma,
	input wire logic [11:0] applied_fast_charge_ma,
	input wire logic [12:0] charge_voltage_mv,
	input wire logic [12:0] recharge_threshold_mv,
	input wire logic        watchdog_expired
);
	logic timer_write;
	assign timer_write = reg_write && reg_addr == 8'h05;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_settled;
		!$past(rst) && !$past(rst, 2);
	endsequence
	sequence s_pre_steady;
		($stable(reduced_current_force) && $stable(precharge_current_ma))[*3];
	endsequence
	sequence s_fast_steady;
		($stable(reduced_current_force)
			&& $stable(fast_charge_current_ma))[*3];
	endsequence
	sequence s_quiet;
		!timer_write && !$past(timer_write) && !$past(timer_write, 2)
			&& !watchdog_kick && !$past(watchdog_kick) && !defaults_load
			&& !$past(defaults_load);
	endsequence
	a_hit_decode: assert property (
		reg_hit == (reg_addr inside {8'h03, 8'h04, 8'h05}))
		else $error("index decode wrong");
	a_unmapped_read: assert property (
		reg_read && !reg_hit |=> reg_rdata == 8'h00)
		else $error("unmapped read returned data");
	a_rdata_holds: assert property (
		!reg_read |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_reserved_zero: assert property (
		reg_read && reg_addr inside {8'h03, 8'h05} |=>
		(reg_rdata & ($past(reg_addr) == 8'h03 ? 8'h08 : 8'h41)) == 8'h00)
		else $error("reserved bit read as one");
	a_recharge_gap: assert property (
		s_settled |-> (charge_voltage_mv - recharge_threshold_mv)
		inside {13'h0064, 13'h012C})
		else $error("recharge offset wrong");
	a_voltage_range: assert property (
		s_settled |-> charge_voltage_mv >= 13'h0DB0
		&& charge_voltage_mv <= 13'h1130)
		else $error("charge voltage out of range");
	a_half_pre: assert property (
		s_pre_steady |-> applied_precharge_ma == (reduced_current_force ?
		precharge_current_ma >> 1 : precharge_current_ma))
		else $error("applied pre-charge wrong");
	a_fifth_fast: assert property (
		s_fast_steady |-> applied_fast_charge_ma == (reduced_current_force ?
		fast_charge_current_ma / 12'h005 : fast_charge_current_ma))
		else $error("applied fast charge wrong");
	a_off_clears: assert property (
		timer_write && reg_wdata[5:4] == 2'b00 && !defaults_load
		|-> ##[1:3] !watchdog_expired)
		else $error("disabled watchdog still expired");
	a_expired_holds: assert property (
		watchdog_expired and s_quiet |=> watchdog_expired)
		else $error("expired flag dropped on its own");
endmodule : charge_parameter_registers_monitor

bind charge_parameter_registers charge_parameter_registers_monitor
	charge_parameter_registers_monitor_i (.clock, .rst, .reg_addr,
	.reg_write, .reg_read, .reg_rdata, .reg_hit, .reg_wdata,
	.defaults_load, .watchdog_kick, .reduced_current_force,
	.fast_charge_current_ma, .precharge_current_ma, .applied_precharge_ma,
	.applied_fast_charge_ma, .charge_voltage_mv, .recharge_threshold_mv,
	.watchdog_expired);

// File: dv/host_port_model.sv
// Host side of the register port: byte writes, reads and watchdog kicks.
// Assumes the bank samples strobes on the rising clock edge.
`timescale 1ns/100ps
module host_port_model (
	input  wire logic       clock,
	output logic      [7:0] reg_addr,
	output logic            reg_write,
	output logic      [7:0] reg_wdata,
	output logic            reg_read,
	input  wire logic [7:0] reg_rdata,
	output logic            watchdog_kick
);
	longint last_kick = -20000;
	initial begin
		reg_addr = 8'h00;
		reg_write = 1'b0;
		reg_wdata = 8'h00;
		reg_read = 1'b0;
		watchdog_kick = 1'b0;
	end
	// Raw writes leave reserved bits as given, to probe the refusal
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit raw);
		logic [7:0] m;
		m = a == 8'h03 ? 8'hF7 : a == 8'h05 ? 8'hBE : 8'hFF;
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= raw ? d : d & m;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(posedge clock);
		#1 d = reg_rdata;
	endtask : rd
	task automatic kick;
		while ($time - last_kick < 20000) @(posedge clock);
		@(posedge clock);
		watchdog_kick <= 1'b1;
		last_kick = $time;
		@(posedge clock);
		watchdog_kick <= 1'b0;
	endtask : kick
endmodule : host_port_model

// File: dv/charge_parameter_registers_tb_top.sv
// Self-checking bench for the charge parameter register bank.
// Assumes the host model owns the register port and the kick.
`timescale 1ns/100ps
module charge_parameter_registers_tb_top;
	import charge_cfg_pkg::*;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        defaults_load = 1'b0;
	logic        reduced_current_force = 1'b0;
	logic [11:0] fast_charge_current_ma = 12'h000;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_val;
	logic        reg_write, reg_read, reg_hit, watchdog_kick;
	logic [11:0] precharge_current_ma, applied_precharge_ma;
	logic [11:0] applied_fast_charge_ma, termination_current_ma;
	logic [11:0] low_battery_threshold_mv;
	logic [12:0] charge_voltage_mv, recharge_threshold_mv, vx;
	logic        termination_enable, safety_timer_enable, watchdog_expired;
	logic [4:0]  fast_charge_limit_hours;
	logic [7:0]  cur [3];
	logic [7:0]  msk [3] = '{8'hF7, 8'hFF, 8'hBE};
	logic [4:0]  hrs [4] = '{5'h05, 5'h08, 5'h0C, 5'h14};
	int          mismatches = 0;
	int          samples_checked = 0;
	int          n;
	always #10 clock = ~clock;
	charge_parameter_registers #(.WDOG_TICK_CYCLES_P(1))
		charge_parameter_registers_i (.clock, .rst, .reg_addr, .reg_write,
		.reg_wdata, .reg_read, .reg_rdata, .reg_hit, .defaults_load,
		.watchdog_kick, .reduced_current_force, .fast_charge_current_ma,
		.precharge_current_ma, .applied_precharge_ma, .applied_fast_charge_ma,
		.termination_current_ma, .charge_voltage_mv, .low_battery_threshold_mv,
		.recharge_threshold_mv, .termination_enable, .safety_timer_enable,
		.fast_charge_limit_hours, .watchdog_expired);
	host_port_model host_port_model_i (.clock, .reg_addr, .reg_write,
		.reg_wdata, .reg_read, .reg_rdata, .watchdog_kick);
	function automatic logic [11:0] pre_exp(input logic [3:0] c);
		if (c < 4'h2) return 12'h080;
		return 12'h080 * (c < 4'h4 ? 12'(c) : 12'(c) + 12'h001);
	endfunction : pre_exp
	function automatic logic [12:0] volt_exp(input logic [5:0] c);
		logic [12:0] t;
		t = 13'h0DB0 + 13'(c) * 13'h0010;
		return t > 13'h1130 ? 13'h1130 : t;
	endfunction : volt_exp
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("compared %0d, mismatched %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish
	task automatic put(input int i, input logic [7:0] d, input bit raw);
		host_port_model_i.wr(8'(i + 3), d, raw);
		cur[i] = d & msk[i];
	endtask : put
	task automatic check_all;
		logic [11:0] p;
		repeat (3) @(posedge clock);
		#1 p = pre_exp(cur[0][7:4]);
		vx = volt_exp(cur[1][7:2]);
		chk("precharge", 16'(p), 16'(precharge_current_ma));
		chk("applied_pre", 16'(reduced_current_force ? p >> 1 : p),
			16'(applied_precharge_ma));
		chk("applied_fast", 16'(reduced_current_force ?
			fast_charge_current_ma / 12'h005 : fast_charge_current_ma),
			16'(applied_fast_charge_ma));
		chk("termination", 16'(12'h080 + 12'(cur[0][2:0]) * 12'h080),
			16'(termination_current_ma));
		chk("voltage", 16'(vx), 16'(charge_voltage_mv));
		chk("low_batt", cur[1][1] ? 16'h0BB8 : 16'h0AF0,
			16'(low_battery_threshold_mv));
		chk("recharge", 16'(vx - (cur[1][0] ? 13'h012C : 13'h0064)),
			16'(recharge_threshold_mv));
		chk("term_en", 16'(cur[2][7]), 16'(termination_enable));
		chk("safety_en", 16'(cur[2][3]), 16'(safety_timer_enable));
		chk("limit", 16'(hrs[cur[2][2:1]]),
			16'(fast_charge_limit_hours));
		for (int i = 0; i < 3; i++) begin
			host_port_model_i.rd(8'(i + 3), rd_val);
			chk("readback", 16'(cur[i]), 16'(rd_val));
		end
		chk("hit", 16'h0001, 16'(reg_hit));
	endtask : check_all
	initial begin
		n = $urandom(32'hA74C96BB);
		cur = '{8'h11, 8'hB2, 8'h9C};
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		check_all;
		for (int c = 0; c < 16; c++) begin
			@(posedge clock);
			reduced_current_force <= c[0];
			fast_charge_current_ma <= 12'($urandom_range(4095));
			put(0, {c[3:0], 1'b1, c[2:0]}, c[1]);
			check_all;
		end
		put(1, 8'h00, 1'b0);
		check_all;
		for (int c = 0; c < 14; c++) begin
			put(1, c == 0 ? 8'hFF : 8'($urandom), 1'b0);
			check_all;
		end
		for (int c = 0; c < 8; c++) begin
			put(2, {c[2], 1'b1, 2'b01, c[0], c[1:0], 1'b1}, 1'b1);
			check_all;
		end
		host_port_model_i.wr(8'h06, 8'hFF, 1'b1);
		host_port_model_i.rd(8'h06, rd_val);
		chk("unmapped", 16'h0000, 16'(rd_val));
		chk("hit", 16'h0000, 16'(reg_hit));
		check_all;
		@(posedge clock);
		defaults_load <= 1'b1;
		@(posedge clock);
		defaults_load <= 1'b0;
		cur = '{8'h11, 8'hB2, 8'h9C};
		check_all;
		host_port_model_i.kick;
		n = 0;
		while (watchdog_expired !== 1'b1 && n < 50000) begin
			@(posedge clock);
			#1 n++;
		end
		chk("wdog_time", 16'h0001, 16'(n >= 39995 && n <= 40005));
		repeat (4) @(posedge clock);
		#1 chk("wdog_stands", 16'h0001, 16'(watchdog_expired));
		host_port_model_i.kick;
		check_all;
		chk("wdog_kicked", 16'h0000, 16'(watchdog_expired));
		put(2, 8'h8C, 1'b0);
		check_all;
		chk("wdog_off", 16'h0000, 16'(watchdog_expired));
		tally_and_finish;
	end
	initial begin
		#(20 * 60000);
		mismatches++;
		tally_and_finish;
	end
endmodule : charge_parameter_registers_tb_top
